// >>> testbench/clock_gating_chk.sv
`timescale 1ns/1ns
`include "clock_gating_defines.svh"

module clock_gating_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire clock_gating_pkg::addr_t wb_adr_i,
    input wire clock_gating_pkg::sel_t wb_sel_i,
    input wire clock_gating_pkg::word_t wb_dat_i,
    input wire clock_gating_pkg::word_t wb_dat_o,
    input wire logic wb_ack_o,
    // peripheral side
    input wire clock_gating_pkg::word_t periphIdle1,
    input wire clock_gating_pkg::word_t clkRun1,
    input wire clock_gating_pkg::word_t clkRun2,
    input wire clock_gating_pkg::word_t autoGate0,
    input wire clock_gating_pkg::word_t autoGate1
);
    import clock_gating_pkg::*;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // low address bits are ignored by the slave, so compare whole words
    logic [7:0] wordAdr;
    logic fullWr;
    assign wordAdr = {wb_adr_i[7:2], 2'b00};
    assign fullWr = wb_ack_o && wb_we_i && (wb_sel_i == 4'hf);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    set_effect_a: assert property (fullWr && wordAdr == `OFS_ENABLE2_SET |-> ##2
        (clkRun2 & $past(wb_dat_i, 2) & `MASK_ENABLE2) == ($past(wb_dat_i, 2) & `MASK_ENABLE2))
        else $error("set alias did not raise enable bits");
    clr_effect_a: assert property (fullWr && wordAdr == `OFS_ENABLE2_CLEAR |-> ##2
        (clkRun2 & $past(wb_dat_i, 2) & `MASK_ENABLE2) == `ZERO_WORD)
        else $error("clear alias did not drop enable bits");
    run2_cause_a: assert property ($changed(clkRun2) |->
        $past(wb_ack_o && wb_we_i && wordAdr[7:4] == 4'h6, 2))
        else $error("enable word 2 changed without a write");
    alias_read_a: assert property (wb_ack_o && !wb_we_i && (wordAdr inside {`OFS_ENABLE1_SET,
        `OFS_ENABLE1_CLEAR, `OFS_ENABLE2_SET, `OFS_ENABLE2_CLEAR}) |-> wb_dat_o == `ZERO_WORD)
        else $error("alias read returned nonzero data");
    run2_mask_a: assert property ((clkRun2 & ~`MASK_ENABLE2) == `ZERO_WORD)
        else $error("reserved enable word 2 bit set");
    auto_rsvd_a: assert property (autoGate0[16] && (autoGate1 & ~`MASK_AUTO1) == `ZERO_WORD)
        else $error("reserved auto-gating bit wrong");
    run1_rsvd_a: assert property ((clkRun1 & ~`MASK_ENABLE1) == `ZERO_WORD)
        else $error("reserved enable word 1 bit set");
    idle_gate_a: assert property (($past(autoGate1 & periphIdle1) & clkRun1) == `ZERO_WORD)
        else $error("idle peripheral clock not gated");
endmodule : clock_gating_chk

bind peripheral_clock_gating_regs clock_gating_chk u_clock_gating_chk (.core_clk, .rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .periphIdle1, .clkRun1, .clkRun2, .autoGate0, .autoGate1);

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`include "clock_gating_defines.svh"

module tb_top;
    import clock_gating_pkg::*;
    // ----------------------------------------------------------------
    // bench state
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    addr_t wb_adr_i = 8'h00;
    sel_t wb_sel_i = 4'h0;
    word_t wb_dat_i = 32'h00000000;
    word_t wb_dat_o, clkRun1, clkRun2, autoGate0, autoGate1;
    word_t periphIdle1 = 32'h00000000;
    logic wb_ack_o;
    int err_total = 0;
    int cmp_count = 0;
    int seed = 32'h8dad;
    word_t q;
    word_t model [4];
    // offset table; kind 0 plain, 1 set, 2 clear, 3 unmapped
    addr_t ofsTab [9] = '{`OFS_ENABLE1, `OFS_ENABLE1_SET, `OFS_ENABLE1_CLEAR, `OFS_ENABLE2,
        `OFS_ENABLE2_SET, `OFS_ENABLE2_CLEAR, `OFS_AUTO0, `OFS_AUTO1, 8'h90};
    int tgtTab [9] = '{0, 0, 0, 1, 1, 1, 2, 3, 0};
    int kindTab [9] = '{0, 1, 2, 0, 1, 2, 0, 0, 3};
    word_t maskTab [4] = '{`MASK_ENABLE1, `MASK_ENABLE2, `MASK_AUTO0, `MASK_AUTO1};

    // 250 MHz clock
    always #2 core_clk = ~core_clk;

    peripheral_clock_gating_regs u_peripheral_clock_gating_regs (.core_clk(core_clk),
        .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .periphIdle1(periphIdle1), .clkRun1(clkRun1),
        .clkRun2(clkRun2), .autoGate0(autoGate0), .autoGate1(autoGate1));

    // ----------------------------------------------------------------
    // expectation model
    // ----------------------------------------------------------------
    function automatic void model_reset();
        model = '{`RESET_ENABLE1, `RESET_ENABLE2, `RESET_AUTO0, `RESET_AUTO1};
    endfunction : model_reset

    // reserved bits never take a write, so the mask folds into the lanes
    function automatic void model_write(int i, word_t d, sel_t s);
        int t;
        word_t m;
        t = tgtTab[i];
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & maskTab[t];
        case (kindTab[i])
            0: model[t] = (model[t] & ~m) | (d & m);
            1: model[t] = model[t] | (d & m);
            2: model[t] = model[t] & ~(d & m);
            default: ;
        endcase
    endfunction : model_write

    task automatic check(string name, word_t seen, word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : check

    // one classic cycle; ack is sampled at the rising edge, and the request
    // is released only after the edge that saw it high
    task automatic bus(int i, logic we, word_t d, sel_t s);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= ofsTab[i] | (8'($random(seed)) & 8'h03);
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) err_total++;
        check("read data", q, (we || kindTab[i] != 0) ? `ZERO_WORD : model[tgtTab[i]]);
        if (we) model_write(i, d, s);
    endtask : bus

    // clock enable outputs settle one edge after the write edge, auto-gate outputs at the write edge itself
    task automatic check_outs();
        @(posedge core_clk);
        @(negedge core_clk);
        check("clkRun1", clkRun1, model[0] & ~(model[3] & periphIdle1));
        check("clkRun2", clkRun2, model[1]);
        check("autoGate0", autoGate0, model[2]);
        check("autoGate1", autoGate1, model[3]);
    endtask : check_outs

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        model_reset();
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        check_outs();
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 9; i++) bus(i, 1'b0, `ZERO_WORD, 4'hf);
            // ones on plain and set offsets, then zero data on each clear alias must change nothing
            for (int i = 0; i < 9; i++) begin
                bus(i, 1'b1, (kindTab[i] == 2) ? `ZERO_WORD : 32'hffffffff, 4'hf);
                check_outs();
            end
            for (int i = 0; i < 9; i++) begin
                bus(i, 1'b1, (kindTab[i] == 1) ? `ZERO_WORD : 32'h5a5aa5a5, 4'hf);
                check_outs();
            end
            // mid-run reset puts every word back
            @(posedge core_clk);
            rst <= 1'b1;
            repeat (3) @(posedge core_clk);
            rst <= 1'b0;
            model_reset();
            check_outs();
        end
        repeat (200) begin
            // idle hints change on a rising edge, like every other input
            @(posedge core_clk);
            periphIdle1 <= $random(seed);
            bus({$random(seed)} % 9, 1'($random(seed)), $random(seed),
                ($random(seed) & 1) ? 4'hf : 4'($random(seed)));
            check_outs();
        end
        print_verdict();
    end

    // watchdog well beyond the expected run length
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule : tb_top

// >>> verilog/clock_gating_defines.svh
`ifndef CLOCK_GATING_DEFINES_SVH
`define CLOCK_GATING_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_ENABLE1 8'h50
`define OFS_ENABLE1_SET 8'h54
`define OFS_ENABLE1_CLEAR 8'h58
`define OFS_ENABLE2 8'h60
`define OFS_ENABLE2_SET 8'h64
`define OFS_ENABLE2_CLEAR 8'h68
`define OFS_AUTO0 8'h80
`define OFS_AUTO1 8'h84

// ----------------------------------------------------------------
// writable bit masks and reset values
// ----------------------------------------------------------------
`define MASK_ENABLE1 32'h3fffffff
`define RESET_ENABLE1 32'h00000000
`define MASK_ENABLE2 32'h000007fe
`define RESET_ENABLE2 32'h00000000
`define MASK_AUTO0 32'hfffeffff
`define RESET_AUTO0 32'h00010200
`define MASK_AUTO1 32'h3f7fffff
`define RESET_AUTO1 32'h00000000

// ----------------------------------------------------------------
// bus shape
// ----------------------------------------------------------------
`define ADDR_WIDTH 8
`define DATA_WIDTH 32
`define SEL_WIDTH 4
`define ZERO_WORD 32'h00000000

`endif

// >>> verilog/clock_gating_pkg.sv
`include "clock_gating_defines.svh"

package clock_gating_pkg;

    // ----------------------------------------------------------------
    // shared types
    // ----------------------------------------------------------------
    typedef logic [`DATA_WIDTH-1:0] word_t;
    typedef logic [`ADDR_WIDTH-1:0] addr_t;
    typedef logic [`SEL_WIDTH-1:0] sel_t;

    // bus slave handshake states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;

    // which register an access selects
    typedef enum logic [3:0] {
        SEL_NONE = 4'b0000,
        SEL_EN1 = 4'b0001,
        SEL_EN1_SET = 4'b0010,
        SEL_EN1_CLR = 4'b0011,
        SEL_EN2 = 4'b0100,
        SEL_EN2_SET = 4'b0101,
        SEL_EN2_CLR = 4'b0110,
        SEL_AUTO0 = 4'b0111,
        SEL_AUTO1 = 4'b1000
    } reg_sel_t;

endpackage : clock_gating_pkg

// >>> verilog/enable_word.sv
`timescale 1ns/1ns
`include "clock_gating_defines.svh"

module enable_word #(
    parameter logic [`DATA_WIDTH-1:0] RESET_VALUE = `ZERO_WORD,
    parameter logic [`DATA_WIDTH-1:0] WRITE_MASK = `ZERO_WORD
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // write controls, one at a time
    input wire logic writeEn,
    input wire logic setEn,
    input wire logic clearEn,
    input wire clock_gating_pkg::word_t writeData,
    input wire clock_gating_pkg::word_t laneMask,
    // stored word
    output clock_gating_pkg::word_t value
);
    import clock_gating_pkg::*;

    word_t word_reg;
    word_t word_next;
    word_t effData;

    // ----------------------------------------------------------------
    // plain write, set alias and clear alias
    // ----------------------------------------------------------------
    always_comb begin
        effData = writeData & laneMask;
        word_next = word_reg;
        if (writeEn) begin
            // unselected byte lanes keep their old contents
            word_next = (word_reg & ~laneMask) | effData;
        end else if (setEn) begin
            word_next = word_reg | effData;
        end else if (clearEn) begin
            word_next = word_reg & ~effData;
        end
        // reserved bits pinned to reset value
        word_next = (word_next & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end

    // storage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word_reg <= RESET_VALUE;
        end else begin
            word_reg <= word_next;
        end
    end

    assign value = word_reg;

endmodule : enable_word

// >>> verilog/peripheral_clock_gating_regs.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
`include "clock_gating_defines.svh"

module peripheral_clock_gating_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire clock_gating_pkg::addr_t wb_adr_i,
    input wire clock_gating_pkg::sel_t wb_sel_i,
    input wire clock_gating_pkg::word_t wb_dat_i,
    output clock_gating_pkg::word_t wb_dat_o,
    output logic wb_ack_o,
    // idle hints from the peripherals behind enable word 1
    input wire clock_gating_pkg::word_t periphIdle1,
    // clock enables towards the peripherals
    output clock_gating_pkg::word_t clkRun1,
    output clock_gating_pkg::word_t clkRun2,
    // auto-gating settings for the peripheral gates
    output clock_gating_pkg::word_t autoGate0,
    output clock_gating_pkg::word_t autoGate1
);
    import clock_gating_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic accessStart;
    logic accessCommit;
    reg_sel_t regSel;
    word_t laneMask;
    word_t enable1;
    word_t enable2;
    word_t auto0;
    word_t auto1;
    word_t readValue;
    word_t rdata_reg;
    word_t rdata_next;
    word_t run1_reg;
    word_t run1_next;
    word_t run2_reg;
    word_t run2_next;
    logic wrCommit;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    wb_slave_port busPort (
        .core_clk(core_clk),
        .rst(rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o),
        .accessStart(accessStart),
        .accessCommit(accessCommit)
    );

    assign wrCommit = accessCommit && wb_we_i;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // low two address bits ignored, every register is one aligned word
    always_comb begin
        case ({wb_adr_i[`ADDR_WIDTH-1:2], 2'b00})
            `OFS_ENABLE1: regSel = SEL_EN1;
            `OFS_ENABLE1_SET: regSel = SEL_EN1_SET;
            `OFS_ENABLE1_CLEAR: regSel = SEL_EN1_CLR;
            `OFS_ENABLE2: regSel = SEL_EN2;
            `OFS_ENABLE2_SET: regSel = SEL_EN2_SET;
            `OFS_ENABLE2_CLEAR: regSel = SEL_EN2_CLR;
            `OFS_AUTO0: regSel = SEL_AUTO0;
            `OFS_AUTO1: regSel = SEL_AUTO1;
            default: regSel = SEL_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // byte lane mask from sel, one generate per lane
    // ----------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < `SEL_WIDTH; lane = lane + 1) begin : gLane
            assign laneMask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
        end
    endgenerate

    // ----------------------------------------------------------------
    // enable words with their aliases
    // ----------------------------------------------------------------
    // word 1: bits 29..0 live, the top two reserved
    enable_word #(
        .RESET_VALUE(`RESET_ENABLE1),
        .WRITE_MASK(`MASK_ENABLE1)
    ) enableWord1 (
        .core_clk(core_clk),
        .rst(rst),
        .writeEn(wrCommit && (regSel == SEL_EN1)),
        .setEn(wrCommit && (regSel == SEL_EN1_SET)),
        .clearEn(wrCommit && (regSel == SEL_EN1_CLR)),
        .writeData(wb_dat_i),
        .laneMask(laneMask),
        .value(enable1)
    );

    // word 2: rom, math unit, gpio and ram bank clocks in bits 10..1
    enable_word #(
        .RESET_VALUE(`RESET_ENABLE2),
        .WRITE_MASK(`MASK_ENABLE2)
    ) enableWord2 (
        .core_clk(core_clk),
        .rst(rst),
        .writeEn(wrCommit && (regSel == SEL_EN2)),
        .setEn(wrCommit && (regSel == SEL_EN2_SET)),
        .clearEn(wrCommit && (regSel == SEL_EN2_CLR)),
        .writeData(wb_dat_i),
        .laneMask(laneMask),
        .value(enable2)
    );

    // ----------------------------------------------------------------
    // automatic gating words, no aliases
    // ----------------------------------------------------------------
    // bit 16 reserved and held at one, bit 9 on from reset
    enable_word #(
        .RESET_VALUE(`RESET_AUTO0),
        .WRITE_MASK(`MASK_AUTO0)
    ) autoWord0 (
        .core_clk(core_clk),
        .rst(rst),
        .writeEn(wrCommit && (regSel == SEL_AUTO0)),
        .setEn(1'b0),
        .clearEn(1'b0),
        .writeData(wb_dat_i),
        .laneMask(laneMask),
        .value(auto0)
    );

    // bits 31, 30 and 23 reserved
    enable_word #(
        .RESET_VALUE(`RESET_AUTO1),
        .WRITE_MASK(`MASK_AUTO1)
    ) autoWord1 (
        .core_clk(core_clk),
        .rst(rst),
        .writeEn(wrCommit && (regSel == SEL_AUTO1)),
        .setEn(1'b0),
        .clearEn(1'b0),
        .writeData(wb_dat_i),
        .laneMask(laneMask),
        .value(auto1)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // aliases and holes read zero so software never mistakes them for state
    always_comb begin
        case (regSel)
            SEL_EN1: readValue = enable1;
            SEL_EN2: readValue = enable2;
            SEL_AUTO0: readValue = auto0;
            SEL_AUTO1: readValue = auto1;
            default: readValue = `ZERO_WORD;
        endcase
    end

    // capture at request start, hold through the ack cycle
    always_comb begin
        rdata_next = rdata_reg;
        if (accessStart) begin
            rdata_next = wb_we_i ? `ZERO_WORD : readValue;
        end
    end

    // read data register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= `ZERO_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign wb_dat_o = rdata_reg;

    // ----------------------------------------------------------------
    // clock enable outputs
    // ----------------------------------------------------------------
    // a running word 1 clock is dropped while its auto-gate bit is on and the
    // peripheral reports idle; registered so the enables are glitch free
    always_comb begin
        run1_next = enable1 & ~(auto1 & periphIdle1);
        run2_next = enable2;
    end

    // clock enable registers, all stopped from reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run1_reg <= `ZERO_WORD;
            run2_reg <= `ZERO_WORD;
        end else begin
            run1_reg <= run1_next;
            run2_reg <= run2_next;
        end
    end

    assign clkRun1 = run1_reg;
    assign clkRun2 = run2_reg;
    // word 0 gates live outside this block, so the setting is exported
    assign autoGate0 = auto0;
    assign autoGate1 = auto1;

endmodule : peripheral_clock_gating_regs

// >>> verilog/wb_slave_port.sv
`timescale 1ns/1ns
`include "clock_gating_defines.svh"

module wb_slave_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    // answer and strobes
    output logic wb_ack_o,
    output logic accessStart,
    output logic accessCommit
);
    import clock_gating_pkg::*;

    bus_state_t state_reg;
    bus_state_t state_next;

    // ----------------------------------------------------------------
    // handshake: one wait cycle, ack for exactly one cycle
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    state_next = BUS_ACK;
                end
            end
            BUS_ACK: begin
                state_next = BUS_IDLE; // ack never held two cycles
            end
            default: begin
                state_next = BUS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // start captures read data, commit applies writes at the ack edge
    assign wb_ack_o = (state_reg == BUS_ACK);
    assign accessStart = (state_reg == BUS_IDLE) && wb_cyc_i && wb_stb_i;
    assign accessCommit = (state_reg == BUS_ACK) && wb_cyc_i && wb_stb_i;

endmodule : wb_slave_port
